// >>> shared/sync_irq_pkg.sv
// constants, types and register map for the sync activity and event block
// assumes one 50 mhz core clock and an apb register port with 32-bit data
// Summary of operation
// - status bit 7 shows pixel pll lock
// - activity bit 0: channel a line sync periodic
// - activity bit 1: channel a frame sync periodic
// - green sync field: 00 none, 01 toggling, 10 periodic
// - channel b in bits 4, 5, 7:6
// - register after activity is unused, ignore reads
// - write one clears a flag unless its set event hits in that cycle, zero keeps
// - flags 0/1 set on channel activity/polarity change
// - flag 4 set on selected sync disruption
// - flag 5 set when selected sync settles
// - flag 6 set every frame sync of the selected channel
// - flag 7 set when phase adjust finishes
// - mask resets to all ones, one masks
// - channel mask zero interrupts on channel changes
// - mask 4 zero interrupts on disruption
// - mask 5 zero interrupts on settling
// - mask 7 zero interrupts on phase adjust

package sync_irq_pkg;

	// ----------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [9:0] IDX_SEL_STATUS = 10'h001;
	localparam logic [9:0] IDX_ACTIVITY = 10'h002;
	localparam logic [9:0] IDX_UNUSED = 10'h003;
	localparam logic [9:0] IDX_FLAGS = 10'h004;
	localparam logic [9:0] IDX_MASK = 10'h005;
	localparam logic [9:0] IDX_INPUT_CFG = 10'h010;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int STAT_PLL_BIT = 7;
	localparam int FLAG_CH_A = 0;
	localparam int FLAG_CH_B = 1;
	localparam int FLAG_DISRUPT = 4;
	localparam int FLAG_SETTLE = 5;
	localparam int FLAG_FRAME = 6;
	localparam int FLAG_PADJ = 7;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] IRQ_VALID = 8'hf3;
	localparam logic [7:0] UNUSED_VALUE = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int LINE_MIN_HZ = 1000;
	localparam int FRAME_MIN_HZ = 20;
	localparam int LINE_MAX_CYC = CLK_HZ / LINE_MIN_HZ;
	localparam int FRAME_MAX_CYC = CLK_HZ / FRAME_MIN_HZ;
	localparam int CNT_W = 22;
	localparam logic [CNT_W-1:0] MATCH_TOL = 22'h000004;

	// ----------------------------------------
	// activity of one sync input
	// ----------------------------------------
	typedef enum logic [2:0] {
		ACT_IDLE = 3'b001,
		ACT_TOGGLE = 3'b010,
		ACT_PERIODIC = 3'b100
	} act_e;

endpackage

// >>> design/sync_activity_detector.sv
// activity, polarity and settling detector for one sync input
// assumes the sync pin is asynchronous to clk

module sync_activity_detector #(
	parameter int MAX_CYC = 50000
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// raw sync pin
	input wire logic sync_pin,
	// measurement results
	output sync_irq_pkg::act_e state,
	output logic active_low,
	output logic changed,
	output logic settled,
	output logic lead_edge
);

	localparam logic [sync_irq_pkg::CNT_W-1:0] LIMIT =
		MAX_CYC[sync_irq_pkg::CNT_W-1:0];

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic [sync_irq_pkg::CNT_W-1:0] cnt;
		logic [sync_irq_pkg::CNT_W-1:0] hi_len;
		logic [sync_irq_pkg::CNT_W-1:0] lo_len;
		logic hi_ok;
		logic lo_ok;
		sync_irq_pkg::act_e st;
		logic low;
		logic unsettled;
		logic changed;
		logic settled;
		logic lead;
		logic [2:0] warm;
	} det_s;

	det_s cur;
	det_s next_cur;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic near(
		input logic [sync_irq_pkg::CNT_W-1:0] a,
		input logic [sync_irq_pkg::CNT_W-1:0] b
	);
		if (a > b)
		begin
			return (a - b) <= sync_irq_pkg::MATCH_TOL;
		end
		return (b - a) <= sync_irq_pkg::MATCH_TOL;
	endfunction

	// ----------------------------------------
	// measurement
	// ----------------------------------------
	always_comb
	begin
		next_cur = cur;
		next_cur.s1 = sync_pin;
		next_cur.s2 = cur.s1;
		next_cur.prev = cur.s2;
		next_cur.changed = 1'b0;
		next_cur.settled = 1'b0;
		next_cur.lead = 1'b0;
		next_cur.warm = {cur.warm[1:0], 1'b1};
		if (cur.warm != 3'b111)
		begin
			// ignore edges until the sync chain holds pin samples
			next_cur.cnt = '0;
		end
		else if (cur.s2 != cur.prev)
		begin
			next_cur.cnt = '0;
			if (cur.prev)
			begin
				next_cur.hi_ok = near(cur.cnt, cur.hi_len);
				next_cur.hi_len = cur.cnt;
			end
			else
			begin
				next_cur.lo_ok = near(cur.cnt, cur.lo_len);
				next_cur.lo_len = cur.cnt;
			end
			next_cur.low = next_cur.hi_len > next_cur.lo_len;
			next_cur.lead = cur.s2 != cur.low;
			if (next_cur.hi_ok && next_cur.lo_ok)
			begin
				next_cur.st = sync_irq_pkg::ACT_PERIODIC;
				if (cur.unsettled)
				begin
					next_cur.unsettled = 1'b0;
					next_cur.settled = 1'b1;
				end
			end
			else
			begin
				next_cur.st = sync_irq_pkg::ACT_TOGGLE;
				if (cur.st == sync_irq_pkg::ACT_PERIODIC)
				begin
					next_cur.changed = 1'b1;
					next_cur.unsettled = 1'b1;
				end
			end
		end
		else if (cur.cnt >= LIMIT)
		begin
			next_cur.st = sync_irq_pkg::ACT_IDLE;
			next_cur.hi_ok = 1'b0;
			next_cur.lo_ok = 1'b0;
			if (cur.st == sync_irq_pkg::ACT_PERIODIC)
			begin
				next_cur.changed = 1'b1;
				next_cur.unsettled = 1'b1;
			end
		end
		else
		begin
			next_cur.cnt = cur.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cur <= '{st: sync_irq_pkg::ACT_IDLE, unsettled: 1'b1,
				default: '0};
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign state = cur.st;
	assign active_low = cur.low;
	assign changed = cur.changed;
	assign settled = cur.settled;
	assign lead_edge = cur.lead;

endmodule

// >>> design/sync_activity_irq_status.sv
// sync activity status, event flags, mask and interrupt with apb access
// assumes pll lock and sync pins are asynchronous, phase adjust done is a
// one-cycle pulse from logic on clk

module sync_activity_irq_status #(
	parameter int LINE_MAX_CYC = sync_irq_pkg::LINE_MAX_CYC,
	parameter int FRAME_MAX_CYC = sync_irq_pkg::FRAME_MAX_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sync inputs, channel a
	input wire logic line_sync_ch_a,
	input wire logic frame_sync_ch_a,
	input wire logic green_embedded_sync_ch_a,
	// sync inputs, channel b
	input wire logic line_sync_ch_b,
	input wire logic frame_sync_ch_b,
	input wire logic green_embedded_sync_ch_b,
	// pll and phase adjust
	input wire logic pll_locked,
	input wire logic phase_adjust_done_event,
	// interrupt
	output logic irq
);

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] mask;
		logic [1:0] in_sel;
		logic pll_s1;
		logic pll_s2;
		logic ready;
		logic slverr;
		logic [7:0] rdata;
		logic irq;
		logic [5:0] sig_a_prev;
		logic [5:0] sig_b_prev;
	} top_s;

	top_s cur;
	top_s next_cur;

	sync_irq_pkg::act_e det_st [6];
	logic [5:0] det_low;
	logic [5:0] det_chg;
	logic [5:0] det_set;
	logic [5:0] det_lead;
	logic [5:0] pins;
	logic [7:0] act_byte;
	logic [7:0] stat_byte;
	logic [5:0] sig_a;
	logic [5:0] sig_b;
	logic [7:0] set_ev;
	logic [9:0] idx;
	logic wr_acc;
	logic sel_b;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic periodic(input sync_irq_pkg::act_e st);
		return st == sync_irq_pkg::ACT_PERIODIC;
	endfunction

	function automatic logic [1:0] sog_code(input sync_irq_pkg::act_e st);
		if (st == sync_irq_pkg::ACT_PERIODIC)
		begin
			return 2'b10;
		end
		else if (st == sync_irq_pkg::ACT_TOGGLE)
		begin
			return 2'b01;
		end
		return 2'b00;
	endfunction

	// ----------------------------------------
	// detectors: line, frame, green for channel a then b
	// ----------------------------------------
	assign pins = {green_embedded_sync_ch_b, frame_sync_ch_b, line_sync_ch_b,
		green_embedded_sync_ch_a, frame_sync_ch_a, line_sync_ch_a};

	for (genvar i = 0; i < 6; i++)
	begin : g_det
		sync_activity_detector #(
			.MAX_CYC((i % 3 == 1) ? FRAME_MAX_CYC : LINE_MAX_CYC)
		) u_det (
			.clk(clk),
			.resetn(resetn),
			.sync_pin(pins[i]),
			.state(det_st[i]),
			.active_low(det_low[i]),
			.changed(det_chg[i]),
			.settled(det_set[i]),
			.lead_edge(det_lead[i])
		);
	end

	// ----------------------------------------
	// status views
	// ----------------------------------------
	always_comb
	begin
		act_byte[0] = periodic(det_st[0]);
		act_byte[1] = periodic(det_st[1]);
		act_byte[3:2] = sog_code(det_st[2]);
		act_byte[4] = periodic(det_st[3]);
		act_byte[5] = periodic(det_st[4]);
		act_byte[7:6] = sog_code(det_st[5]);
		sig_a = {det_low[1:0], act_byte[3:0]};
		sig_b = {det_low[4:3], act_byte[7:4]};
		sel_b = cur.in_sel[0];
		stat_byte = 8'h00;
		stat_byte[sync_irq_pkg::STAT_PLL_BIT] = cur.pll_s2;
		stat_byte[3:2] = sel_b ? det_low[4:3] : det_low[1:0];
		if (periodic(sel_b ? det_st[5] : det_st[2]))
		begin
			stat_byte[1:0] = 2'b11;
		end
		else if (sel_b ? (act_byte[4] && act_byte[5])
			: (act_byte[0] && act_byte[1]))
		begin
			stat_byte[1:0] = 2'b01;
		end
	end

	// ----------------------------------------
	// events
	// ----------------------------------------
	always_comb
	begin
		set_ev = 8'h00;
		set_ev[sync_irq_pkg::FLAG_CH_A] = (sig_a != cur.sig_a_prev)
			|| det_set[0] || det_set[1];
		set_ev[sync_irq_pkg::FLAG_CH_B] = (sig_b != cur.sig_b_prev)
			|| det_set[3] || det_set[4];
		set_ev[sync_irq_pkg::FLAG_DISRUPT] = sel_b
			? (det_chg[3] || det_chg[4]) : (det_chg[0] || det_chg[1]);
		set_ev[sync_irq_pkg::FLAG_SETTLE] = sel_b
			? (det_set[3] || det_set[4]) : (det_set[0] || det_set[1]);
		set_ev[sync_irq_pkg::FLAG_FRAME] = sel_b
			? det_lead[4] : det_lead[1];
		set_ev[sync_irq_pkg::FLAG_PADJ] = phase_adjust_done_event;
	end

	// ----------------------------------------
	// register file and apb
	// ----------------------------------------
	assign idx = paddr[11:2];
	assign wr_acc = psel && penable && cur.ready && pwrite && !cur.slverr;

	always_comb
	begin
		next_cur = cur;
		next_cur.pll_s1 = pll_locked;
		next_cur.pll_s2 = cur.pll_s1;
		next_cur.sig_a_prev = sig_a;
		next_cur.sig_b_prev = sig_b;
		next_cur.ready = psel && !penable;
		next_cur.slverr = 1'b0;
		if (psel && !penable)
		begin
			next_cur.rdata = 8'h00;
			if (paddr[1:0] != 2'b00)
			begin
				next_cur.slverr = 1'b1;
			end
			else if (idx == sync_irq_pkg::IDX_SEL_STATUS)
			begin
				next_cur.rdata = stat_byte;
			end
			else if (idx == sync_irq_pkg::IDX_ACTIVITY)
			begin
				next_cur.rdata = act_byte;
			end
			else if (idx == sync_irq_pkg::IDX_UNUSED)
			begin
				next_cur.rdata = sync_irq_pkg::UNUSED_VALUE;
			end
			else if (idx == sync_irq_pkg::IDX_FLAGS)
			begin
				next_cur.rdata = cur.flags;
			end
			else if (idx == sync_irq_pkg::IDX_MASK)
			begin
				next_cur.rdata = cur.mask;
			end
			else if (idx == sync_irq_pkg::IDX_INPUT_CFG)
			begin
				next_cur.rdata = {6'h00, cur.in_sel};
			end
			else
			begin
				next_cur.slverr = 1'b1;
			end
		end
		next_cur.flags = cur.flags;
		if (wr_acc && idx == sync_irq_pkg::IDX_FLAGS)
		begin
			next_cur.flags = cur.flags & ~pwdata[7:0];
		end
		if (wr_acc && idx == sync_irq_pkg::IDX_MASK)
		begin
			next_cur.mask = pwdata[7:0];
		end
		if (wr_acc && idx == sync_irq_pkg::IDX_INPUT_CFG)
		begin
			next_cur.in_sel = pwdata[1:0];
		end
		next_cur.flags = (next_cur.flags | set_ev)
			& sync_irq_pkg::IRQ_VALID;
		next_cur.irq = |(next_cur.flags & ~next_cur.mask
			& sync_irq_pkg::IRQ_VALID);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cur <= '{mask: sync_irq_pkg::MASK_RESET, default: '0};
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign prdata = {24'h000000, cur.rdata};
	assign pready = cur.ready;
	assign pslverr = cur.slverr;
	assign irq = cur.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_pll_read;
		@(posedge clk) disable iff (!resetn)
		(psel && !penable && paddr == {sync_irq_pkg::IDX_SEL_STATUS, 2'b00})
		|=> prdata[7] == $past(cur.pll_s2);
	endproperty
	a_pll_read: assert property (p_pll_read) else $error("pll bit");

	property p_line_a;
		@(posedge clk) disable iff (!resetn)
		(psel && !penable && paddr == {sync_irq_pkg::IDX_ACTIVITY, 2'b00})
		|=> prdata[0] == $past(act_byte[0]);
	endproperty
	a_line_a: assert property (p_line_a) else $error("line a bit");

	property p_sog_code;
		@(posedge clk) disable iff (!resetn)
		(det_st[2] == sync_irq_pkg::ACT_IDLE) |-> act_byte[3:2] == 2'b00;
	endproperty
	a_sog_code: assert property (p_sog_code) else $error("green code");

	property p_w1c;
		@(posedge clk) disable iff (!resetn)
		(wr_acc && idx == sync_irq_pkg::IDX_FLAGS && pwdata[6]
			&& !set_ev[6]) |=> !cur.flags[6];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");

	property p_ch_a_flag;
		@(posedge clk) disable iff (!resetn)
		set_ev[sync_irq_pkg::FLAG_CH_A] |=> cur.flags[0];
	endproperty
	a_ch_a_flag: assert property (p_ch_a_flag) else $error("ch a flag");

	property p_disrupt;
		@(posedge clk) disable iff (!resetn)
		(!cur.in_sel[0] && (det_chg[0] || det_chg[1])) |=> cur.flags[4];
	endproperty
	a_disrupt: assert property (p_disrupt) else $error("disrupt flag");

	property p_frame_irq;
		@(posedge clk) disable iff (!resetn)
		(set_ev[6] && !cur.mask[6] && !wr_acc) |=> cur.flags[6] && irq;
	endproperty
	a_frame_irq: assert property (p_frame_irq) else $error("frame irq");

	property p_padj;
		@(posedge clk) disable iff (!resetn)
		phase_adjust_done_event |=> cur.flags[7];
	endproperty
	a_padj: assert property (p_padj) else $error("phase flag");

	property p_mask_hold;
		@(posedge clk) disable iff (!resetn)
		!(wr_acc && idx == sync_irq_pkg::IDX_MASK) |=> $stable(cur.mask);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask moved");

	property p_no_23;
		@(posedge clk) disable iff (!resetn)
		cur.flags[3:2] == 2'b00;
	endproperty
	a_no_23: assert property (p_no_23) else $error("flag 2 or 3 set");

	property p_irq_off;
		@(posedge clk) disable iff (!resetn)
		((cur.flags & ~cur.mask) == 8'h00) |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("stray irq");

	property p_irq_ch;
		@(posedge clk) disable iff (!resetn)
		((|(set_ev[1:0] & ~cur.mask[1:0])) && !wr_acc) |=> irq;
	endproperty
	a_irq_ch: assert property (p_irq_ch) else $error("irq 0 or 1");

	property p_irq_dis;
		@(posedge clk) disable iff (!resetn)
		(set_ev[4] && !cur.mask[4] && !wr_acc) |=> irq;
	endproperty
	a_irq_dis: assert property (p_irq_dis) else $error("irq 4");

	property p_irq_set;
		@(posedge clk) disable iff (!resetn)
		(set_ev[5] && !cur.mask[5] && !wr_acc) |=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq 5");

	property p_irq_padj;
		@(posedge clk) disable iff (!resetn)
		(phase_adjust_done_event && !cur.mask[7] && !wr_acc) |=> irq;
	endproperty
	a_irq_padj: assert property (p_irq_padj) else $error("irq 7");

endmodule

// >>> verification/sync_source.sv
// sync pulse source standing in for one analog sync input
// assumes the bench clock; the pin holds its level while stopped
module sync_source #(
	parameter int HALF = 20,
	parameter bit WOB = 1'b0
) (
	// clock and control
	input wire logic clk,
	input wire logic run,
	// sync pin
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00;
	logic [1:0] step = 2'h0;
	logic [7:0] len;
	// wobble steps the length over four phases, so no phase matches the last one of its level
	assign len = 8'(HALF) + (WOB ? {3'h0, step, 3'h0} : 8'h00);
	initial pin = 1'b0;
	always @(posedge clk)
	begin
		if (run)
		begin
			if (cnt + 8'h01 >= len)
			begin
				pin <= ~pin;
				cnt <= 8'h00;
				step <= step + 2'h1;
			end
			else
				cnt <= cnt + 8'h01;
		end
	end
endmodule

// >>> verification/tb.sv
// self-checking bench for the sync activity and event block
// assumes apb slave timing as handed over, sources from sync_source
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	wire [5:0] pins;
	logic [5:0] run = 6'h00;
	logic pll_locked = 1'b0;
	logic padj = 1'b0;
	logic irq;
	logic [31:0] rd;
	logic err;
	int error_cnt = 0;
	int n_checks = 0;
	localparam int half[6] = '{20, 100, 20, 20, 100, 20};
	always #10 clk = ~clk;

	// ----------------------------------------
	// sources and device
	// ----------------------------------------
	for (genvar i = 0; i < 6; i++)
	begin : g_src
		sync_source #(.HALF(half[i]), .WOB(i == 5)) src (
			.clk(clk), .run(run[i]), .pin(pins[i]));
	end
	sync_activity_irq_status #(.LINE_MAX_CYC(200), .FRAME_MAX_CYC(2000)) uut (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.line_sync_ch_a(pins[0]), .frame_sync_ch_a(pins[1]),
		.green_embedded_sync_ch_a(pins[2]), .line_sync_ch_b(pins[3]),
		.frame_sync_ch_b(pins[4]), .green_embedded_sync_ch_b(pins[5]),
		.pll_locked(pll_locked), .phase_adjust_done_event(padj), .irq(irq));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			error_cnt++;
			stop_test();
		end
	endtask
	task automatic rdc(input string name, input logic [11:0] a,
		input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd & m, exp);
	endtask
	task automatic wait_irq(input logic exp, input int bound);
		int n;
		n = 0;
		while (irq !== exp && n < bound)
		begin
			@(posedge clk);
			n++;
		end
		check("irq", {31'h0, irq}, {31'h0, exp});
		if (irq !== exp)
			stop_test();
	endtask
	// clear flags, set mask, then change one source and await the interrupt
	task automatic ev(input logic [7:0] m, input int i, input logic on);
		apb(1'b1, 12'h010, 32'hff);
		apb(1'b1, 12'h014, {24'h0, m});
		wait_irq(1'b0, 4);
		run[i] <= on;
		wait_irq(1'b1, 900);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rdc("mask", 12'h014, 32'hffffffff, 32'hff);
		check("slverr", {31'h0, err}, 32'h0);
		rdc("flags", 12'h010, 32'hffffffff, 32'h0);
		rdc("activity", 12'h008, 32'hffffffff, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		pll_locked <= 1'b1;
		repeat (4) @(posedge clk);
		rdc("pll", 12'h004, 32'h80, 32'h80);
		pll_locked <= 1'b0;
		repeat (4) @(posedge clk);
		rdc("pll", 12'h004, 32'h80, 32'h0);
		apb(1'b1, 12'h014, 32'h5a);
		rdc("mask", 12'h014, 32'hffffffff, 32'h5a);
		apb(1'b1, 12'h014, 32'hff);
		run <= 6'h3f;
		repeat (800) @(posedge clk);
		rdc("activity", 12'h008, 32'hffffffff, 32'h7b);
		rdc("flags", 12'h010, 32'hbf, 32'h23);
		check("irq", {31'h0, irq}, 32'h0);
		apb(1'b1, 12'h010, 32'h0);
		rdc("flags", 12'h010, 32'hbf, 32'h23);
		apb(1'b1, 12'h010, 32'h21);
		rdc("flags", 12'h010, 32'hbf, 32'h02);
		apb(1'b1, 12'h010, 32'hff);
		rdc("flags", 12'h010, 32'hbf, 32'h0);
		apb(1'b1, 12'h014, 32'hbf);
		wait_irq(1'b1, 300);
		rdc("flags", 12'h010, 32'h40, 32'h40);
		apb(1'b1, 12'h014, 32'hf3);
		wait_irq(1'b0, 4);
		repeat (20) @(posedge clk);
		check("irq", {31'h0, irq}, 32'h0);
		apb(1'b1, 12'h014, 32'h7f);
		padj <= 1'b1;
		@(posedge clk);
		padj <= 1'b0;
		wait_irq(1'b1, 10);
		rdc("flags", 12'h010, 32'h80, 32'h80);
		ev(8'hef, 0, 1'b0);
		rdc("activity", 12'h008, 32'hffffffff, 32'h7a);
		rdc("flags", 12'h010, 32'h10, 32'h10);
		ev(8'hdf, 0, 1'b1);
		ev(8'hfe, 0, 1'b0);
		ev(8'hfd, 3, 1'b0);
		apb(1'b1, 12'h040, 32'h1);
		rdc("select", 12'h040, 32'h3, 32'h1);
		ev(8'hdf, 3, 1'b1);
		rdc("flags", 12'h010, 32'h22, 32'h22);
		ev(8'hef, 3, 1'b0);
		rdc("flags", 12'h010, 32'h10, 32'h10);
		stop_test();
	end
endmodule
